// >>> include/rtw_defs.svh
`ifndef RTW_DEFS_SVH
`define RTW_DEFS_SVH

// device address on the two-wire bus (1101000)
`define RTW_DEV_ADDR   7'h68
// register pointer width and its value after reset
`define RTW_PTR_W      6
`define RTW_PTR_RST    6'h00
// bit counter: data bits per byte, ninth clock is the acknowledge
`define RTW_CNT_ZERO   4'h0
`define RTW_CNT_BYTE   4'h8
// master side timing
`define RTW_CLK_NS     10
`define RTW_QTR_NS     2500
`define RTW_QTR_CYC    ((`RTW_QTR_NS + `RTW_CLK_NS - 1) / `RTW_CLK_NS)
`define RTW_TMR_W      16
// phases of one bus clock period on the master side
`define RTW_PH0        2'h0
`define RTW_PH1        2'h1
`define RTW_PH2        2'h2

`endif

// >>> include/rtw_pkg.sv
package rtw_pkg;

  // master command set
  typedef enum logic [1:0] {
    RTW_CMD_START,
    RTW_CMD_WRITE,
    RTW_CMD_READ,
    RTW_CMD_STOP
  } rtw_cmd_t;

  // slave bus states
  typedef enum logic [2:0] {
    SL_IDLE,
    SL_ADDR,
    SL_RX,
    SL_ACK,
    SL_TX,
    SL_TXACK,
    SL_SKIP
  } rtw_sl_st_t;

  // master sequencer states
  typedef enum logic [1:0] {
    MS_IDLE,
    MS_START,
    MS_BYTE,
    MS_STOP
  } rtw_ms_st_t;

endpackage : rtw_pkg

// >>> include/rtw_if.sv
interface rtw_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  logic sda;

  // open-drain data line with pull-up
  assign sda = ((!sda_m_oe_n && !sda_m_o) || (!sda_s_oe_n && !sda_s_o)) ? 1'b0 : 1'b1;

  modport master (
    output scl,
    output sda_m_o,
    output sda_m_oe_n,
    input  sda
  );

  modport slave (
    input  scl,
    input  sda,
    output sda_s_o,
    output sda_s_oe_n
  );
endinterface : rtw_if

// >>> core/rtw_sync.sv
module rtw_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk_i,
  // asynchronous levels in, filtered levels out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // a change counts once the second and third stage agree
  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        q_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    s1_r <= d_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
    q_r  <= q_nxt;
  end

  assign q_o = q_r;
endmodule : rtw_sync

// >>> core/rtw_slave.sv
// Notes on behaviour
// - address 1101000 plus zero selects write
// - same address plus one selects read
// - matching address acknowledged low on ninth clock
// - first written byte loads register pointer
// - acknowledge and store each further written byte
// - master ends a write with STOP
// - every byte travels most significant bit first
// - read starts at current register pointer
// - without pointer write, keep previous pointer
// - master acknowledges all but last read byte
// - keep sending until master does not acknowledge
// - START begins, STOP ends any transfer
// - repeated START restarts with new address byte
// - master makes all clocks, START and STOP
// - pointer advances per byte, wraps 3Fh to 00h
// - release data line after master's not-acknowledge
`include "rtw_defs.svh"

module rtw_slave
  import rtw_pkg::*;
#(
  parameter int PTR_W = `RTW_PTR_W
) (
  // link clock and reset
  input  wire logic             lnk_clk_i,
  input  wire logic             sys_rst_i,
  // two-wire bus
  rtw_if.slave                  bus,
  // user side
  output logic                  wr_stb_o,
  output logic      [PTR_W-1:0] wr_addr_o,
  output logic      [7:0]       wr_data_o,
  output logic      [PTR_W-1:0] ptr_o,
  output logic                  sel_o
);
  localparam int DEPTH = 2 ** PTR_W;

  logic [2:0]       line_s;
  logic             rst;
  logic             scl_s;
  logic             sda_s;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic             load_tx;

  rtw_sl_st_t       st_r;
  rtw_sl_st_t       st_nxt;
  logic [3:0]       cnt_r;
  logic [3:0]       cnt_nxt;
  logic [7:0]       sh_r;
  logic [7:0]       sh_nxt;
  logic [7:0]       tx_r;
  logic [7:0]       tx_nxt;
  logic [PTR_W-1:0] ptr_r;
  logic [PTR_W-1:0] ptr_nxt;
  logic             rd_r;
  logic             rd_nxt;
  logic             first_r;
  logic             first_nxt;
  logic             ack_r;
  logic             ack_nxt;
  logic             drv_r;
  logic             drv_nxt;
  logic             scl_q_r;
  logic             sda_q_r;
  logic             wr_stb_r;
  logic             wr_stb_nxt;
  logic [PTR_W-1:0] wr_addr_r;
  logic [PTR_W-1:0] wr_addr_nxt;
  logic [7:0]       wr_data_r;
  logic [7:0]       wr_data_nxt;
  logic             sel_r;
  logic             sel_nxt;

  logic [7:0]       mem [DEPTH];
  logic             mem_we;
  logic [PTR_W-1:0] mem_wa;
  logic [7:0]       mem_wd;

  // reset and bus lines into the link domain
  rtw_sync #(
    .W (3)
  ) u_sync (
    .clk_i (lnk_clk_i),
    .d_i   ({sys_rst_i, bus.scl, bus.sda}),
    .q_o   (line_s)
  );

  assign rst   = line_s[2];
  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  // bus events
  assign scl_rise  = scl_s & ~scl_q_r;
  assign scl_fall  = ~scl_s & scl_q_r;
  assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;

  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    sh_nxt      = sh_r;
    tx_nxt      = tx_r;
    ptr_nxt     = ptr_r;
    rd_nxt      = rd_r;
    first_nxt   = first_r;
    ack_nxt     = ack_r;
    drv_nxt     = drv_r;
    wr_stb_nxt  = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    mem_we      = 1'b0;
    mem_wa      = ptr_r;
    mem_wd      = sh_r;
    load_tx     = 1'b0;
    if (start_det) begin
      // a new transfer always opens with an address byte
      st_nxt  = SL_ADDR;
      cnt_nxt = `RTW_CNT_ZERO;
      drv_nxt = 1'b0;
    end else if (stop_det) begin
      st_nxt  = SL_IDLE;
      drv_nxt = 1'b0;
    end else begin
      case (st_r)
        SL_ADDR, SL_RX: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == `RTW_CNT_BYTE) begin
            cnt_nxt = `RTW_CNT_ZERO;
            if (st_r == SL_ADDR) begin
              if (sh_r[7:1] == `RTW_DEV_ADDR) begin
                rd_nxt    = sh_r[0];
                first_nxt = ~sh_r[0];
                drv_nxt   = 1'b1;
                st_nxt    = SL_ACK;
              end else begin
                st_nxt = SL_SKIP;
              end
            end else begin
              if (first_r) begin
                ptr_nxt = sh_r[PTR_W-1:0];
              end else begin
                mem_we      = 1'b1;
                wr_stb_nxt  = 1'b1;
                wr_addr_nxt = ptr_r;
                wr_data_nxt = sh_r;
                ptr_nxt     = ptr_r + 1'b1;
              end
              first_nxt = 1'b0;
              drv_nxt   = 1'b1;
              st_nxt    = SL_ACK;
            end
          end
        end
        SL_ACK: begin
          if (scl_fall) begin
            if (rd_r) begin
              load_tx = 1'b1;
            end else begin
              drv_nxt = 1'b0;
              st_nxt  = SL_RX;
            end
          end
        end
        SL_TX: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == `RTW_CNT_BYTE) begin
              cnt_nxt = `RTW_CNT_ZERO;
              drv_nxt = 1'b0;
              st_nxt  = SL_TXACK;
            end else begin
              tx_nxt  = {tx_r[6:0], 1'b0};
              drv_nxt = ~tx_r[6];
            end
          end
        end
        SL_TXACK: begin
          if (scl_rise) begin
            ack_nxt = ~sda_s;
          end else if (scl_fall) begin
            if (ack_r) begin
              load_tx = 1'b1;
            end else begin
              drv_nxt = 1'b0;
              st_nxt  = SL_SKIP;
            end
          end
        end
        SL_IDLE, SL_SKIP: begin
          drv_nxt = 1'b0;
        end
        default: begin
          st_nxt  = SL_IDLE;
          drv_nxt = 1'b0;
        end
      endcase
      if (load_tx) begin
        // read streams from the pointer left by any earlier access
        tx_nxt  = mem[ptr_r];
        drv_nxt = ~mem[ptr_r][7];
        ptr_nxt = ptr_r + 1'b1;
        cnt_nxt = `RTW_CNT_ZERO;
        st_nxt  = SL_TX;
      end
    end
    sel_nxt = (st_nxt != SL_IDLE) && (st_nxt != SL_SKIP) && (st_nxt != SL_ADDR);
  end

  always_ff @(posedge lnk_clk_i) begin
    if (rst) begin
      st_r      <= SL_IDLE;
      cnt_r     <= `RTW_CNT_ZERO;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= `RTW_PTR_RST;
      rd_r      <= 1'b0;
      first_r   <= 1'b0;
      ack_r     <= 1'b0;
      drv_r     <= 1'b0;
      scl_q_r   <= 1'b1;
      sda_q_r   <= 1'b1;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= `RTW_PTR_RST;
      wr_data_r <= 8'h00;
      sel_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      sh_r      <= sh_nxt;
      tx_r      <= tx_nxt;
      ptr_r     <= ptr_nxt;
      rd_r      <= rd_nxt;
      first_r   <= first_nxt;
      ack_r     <= ack_nxt;
      drv_r     <= drv_nxt;
      scl_q_r   <= scl_s;
      sda_q_r   <= sda_s;
      wr_stb_r  <= wr_stb_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      sel_r     <= sel_nxt;
    end
  end

  // register storage, no reset
  always_ff @(posedge lnk_clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // open-drain data output, clock line never driven
  assign bus.sda_s_o    = 1'b0;
  assign bus.sda_s_oe_n = ~drv_r;
  assign wr_stb_o       = wr_stb_r;
  assign wr_addr_o      = wr_addr_r;
  assign wr_data_o      = wr_data_r;
  assign ptr_o          = ptr_r;
  assign sel_o          = sel_r;
endmodule : rtw_slave

// >>> core/rtw_master.sv
`include "rtw_defs.svh"

module rtw_master
  import rtw_pkg::*;
#(
  parameter int QTR_CYC = `RTW_QTR_CYC
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // two-wire bus
  rtw_if.master           bus,
  // command port
  input  wire logic       cmd_valid_i,
  input  wire rtw_cmd_t   cmd_i,
  input  wire logic [7:0] wr_byte_i,
  input  wire logic       nack_i,
  output logic            cmd_ready_o,
  // answer port
  output logic            done_o,
  output logic      [7:0] rd_byte_o,
  output logic            ack_o
);
  localparam logic [`RTW_TMR_W-1:0] QTR_LAST = `RTW_TMR_W'(QTR_CYC - 1);

  logic                  sda_s;
  logic                  tick;
  rtw_ms_st_t            st_r;
  rtw_ms_st_t            st_nxt;
  logic [`RTW_TMR_W-1:0] q_r;
  logic [`RTW_TMR_W-1:0] q_nxt;
  logic [1:0]            ph_r;
  logic [1:0]            ph_nxt;
  logic [3:0]            bit_r;
  logic [3:0]            bit_nxt;
  logic [7:0]            sh_r;
  logic [7:0]            sh_nxt;
  logic                  rd_r;
  logic                  rd_nxt;
  logic                  nack_r;
  logic                  nack_nxt;
  logic                  scl_r;
  logic                  scl_nxt;
  logic                  drv_r;
  logic                  drv_nxt;
  logic                  done_r;
  logic                  done_nxt;
  logic [7:0]            rdb_r;
  logic [7:0]            rdb_nxt;
  logic                  ack_r;
  logic                  ack_nxt;

  rtw_sync #(
    .W (1)
  ) u_sync (
    .clk_i (ref_clk_i),
    .d_i   (bus.sda),
    .q_o   (sda_s)
  );

  assign tick = (q_r == QTR_LAST);

  always_comb begin
    st_nxt   = st_r;
    q_nxt    = q_r;
    ph_nxt   = ph_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    rd_nxt   = rd_r;
    nack_nxt = nack_r;
    scl_nxt  = scl_r;
    drv_nxt  = drv_r;
    done_nxt = 1'b0;
    rdb_nxt  = rdb_r;
    ack_nxt  = ack_r;
    if (st_r == MS_IDLE) begin
      if (cmd_valid_i) begin
        q_nxt    = '0;
        ph_nxt   = `RTW_PH0;
        bit_nxt  = `RTW_CNT_ZERO;
        sh_nxt   = wr_byte_i;
        rd_nxt   = (cmd_i == RTW_CMD_READ);
        nack_nxt = nack_i;
        case (cmd_i)
          RTW_CMD_START: st_nxt = MS_START;
          RTW_CMD_STOP: begin
            st_nxt  = MS_STOP;
            scl_nxt = 1'b0;
          end
          default: begin
            st_nxt  = MS_BYTE;
            scl_nxt = 1'b0;
          end
        endcase
      end
    end else begin
      q_nxt = tick ? '0 : q_r + 1'b1;
      if (tick) begin
        ph_nxt = ph_r + 2'h1;
        case (st_r)
          MS_START: begin
            case (ph_r)
              `RTW_PH0: drv_nxt = 1'b0;
              `RTW_PH1: scl_nxt = 1'b1;
              `RTW_PH2: drv_nxt = 1'b1;
              default: begin
                st_nxt   = MS_IDLE;
                done_nxt = 1'b1;
              end
            endcase
          end
          MS_STOP: begin
            case (ph_r)
              `RTW_PH0: drv_nxt = 1'b1;
              `RTW_PH1: scl_nxt = 1'b1;
              `RTW_PH2: drv_nxt = 1'b0;
              default: begin
                st_nxt   = MS_IDLE;
                done_nxt = 1'b1;
              end
            endcase
          end
          MS_BYTE: begin
            case (ph_r)
              `RTW_PH0: drv_nxt = (bit_r == `RTW_CNT_BYTE) ? (rd_r & ~nack_r) : (~rd_r & ~sh_r[7]);
              `RTW_PH1: scl_nxt = 1'b1;
              `RTW_PH2: scl_nxt = 1'b1;
              default: begin
                scl_nxt = 1'b0;
                bit_nxt = bit_r + 4'h1;
                if (bit_r == `RTW_CNT_BYTE) begin
                  ack_nxt  = ~sda_s;
                  st_nxt   = MS_IDLE;
                  done_nxt = 1'b1;
                  if (rd_r) begin
                    rdb_nxt = sh_r;
                  end
                end else begin
                  sh_nxt = {sh_r[6:0], sda_s};
                end
              end
            endcase
          end
          default: st_nxt = MS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_r   <= MS_IDLE;
      q_r    <= '0;
      ph_r   <= `RTW_PH0;
      bit_r  <= `RTW_CNT_ZERO;
      sh_r   <= 8'h00;
      rd_r   <= 1'b0;
      nack_r <= 1'b0;
      scl_r  <= 1'b1;
      drv_r  <= 1'b0;
      done_r <= 1'b0;
      rdb_r  <= 8'h00;
      ack_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      q_r    <= q_nxt;
      ph_r   <= ph_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      rd_r   <= rd_nxt;
      nack_r <= nack_nxt;
      scl_r  <= scl_nxt;
      drv_r  <= drv_nxt;
      done_r <= done_nxt;
      rdb_r  <= rdb_nxt;
      ack_r  <= ack_nxt;
    end
  end

  assign bus.scl        = scl_r;
  assign bus.sda_m_o    = 1'b0;
  assign bus.sda_m_oe_n = ~drv_r;
  assign cmd_ready_o    = (st_r == MS_IDLE);
  assign done_o         = done_r;
  assign rd_byte_o      = rdb_r;
  assign ack_o          = ack_r;
endmodule : rtw_master

// >>> tb/rtw_checker.sv
`include "rtw_defs.svh"

module rtw_checker (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // two-wire bus
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sda_s_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       scl_r, sda_r, adr_r, mat_r, rd_r, skp_r, nak_r;
  logic       adr_nxt, mat_nxt, rd_nxt, skp_nxt, nak_nxt, rise, start, stop;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;

  // bit and byte tracking on the wire
  always_comb begin
    rise    = scl && !scl_r;
    start   = scl && scl_r && sda_r && !sda;
    stop    = scl && scl_r && !sda_r && sda;
    cnt_nxt = cnt_r;
    sh_nxt  = sh_r;
    adr_nxt = adr_r;
    mat_nxt = mat_r;
    rd_nxt  = rd_r;
    skp_nxt = skp_r;
    nak_nxt = nak_r;
    if (start || stop) begin
      cnt_nxt = `RTW_CNT_ZERO;
      adr_nxt = start;
      mat_nxt = 1'b0;
      skp_nxt = 1'b0;
      nak_nxt = 1'b0;
    end else if (rise && cnt_r != `RTW_CNT_BYTE) begin
      sh_nxt  = {sh_r[6:0], sda};
      cnt_nxt = cnt_r + 4'h1;
    end else if (rise) begin
      cnt_nxt = `RTW_CNT_ZERO;
      adr_nxt = 1'b0;
      if (adr_r) begin
        mat_nxt = (sh_r[7:1] == `RTW_DEV_ADDR);
        rd_nxt  = sh_r[0];
        skp_nxt = (sh_r[7:1] != `RTW_DEV_ADDR);
      end else if (mat_r && rd_r && sda) begin
        nak_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      {scl_r, sda_r, adr_r, mat_r, rd_r, skp_r, nak_r, cnt_r, sh_r} <= {2'h3, 5'h00, 4'h0, 8'h00};
    end else begin
      {scl_r, sda_r, adr_r, mat_r, rd_r, skp_r, nak_r} <= {scl, sda, adr_nxt, mat_nxt, rd_nxt, skp_nxt, nak_nxt};
      {cnt_r, sh_r} <= {cnt_nxt, sh_nxt};
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_ack_clk;
    rise && cnt_r == `RTW_CNT_BYTE;
  endsequence

  sequence s_addr_hit;
    s_ack_clk ##0 (adr_r && sh_r[7:1] == `RTW_DEV_ADDR);
  endsequence

  a_slave_no_ctrl: assert property ($changed(sda_s_oe_n) |-> !scl)
    else $error("slave moved data line while clock high");
  a_addr_ack: assert property (s_addr_hit |-> (!sda) [*8])
    else $error("own address not acknowledged");
  a_foreign_noack: assert property (s_ack_clk ##0 (adr_r && sh_r[7:1] != `RTW_DEV_ADDR) |-> sda)
    else $error("foreign address acknowledged");
  a_foreign_quiet: assert property (skp_r |-> sda_s_oe_n)
    else $error("slave drove line after foreign address");
  a_addr_listen: assert property (adr_r && cnt_r != `RTW_CNT_BYTE |-> sda_s_oe_n)
    else $error("slave drove line during address bits");
  a_write_ack: assert property (s_ack_clk ##0 (!adr_r && mat_r && !rd_r) |-> !sda)
    else $error("written byte not acknowledged");
  a_read_release: assert property (s_ack_clk ##0 (!adr_r && mat_r && rd_r) |-> sda_s_oe_n)
    else $error("slave drove line in master acknowledge slot");
  a_nack_release: assert property (nak_r |-> sda_s_oe_n)
    else $error("slave drove line after not-acknowledge");
endmodule : rtw_checker

// >>> tb/tb_top.sv
`include "rtw_defs.svh"

module tb_top
  import rtw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int QTR   = 16;
  localparam int LIMIT = 60000;

  // stimulus and observed outputs
  logic        ref_clk_i       = 1'b0;
  logic        lnk_clk_i       = 1'b0;
  logic        sys_rst_i       = 1'b1;
  logic        cmd_valid_i     = 1'b0;
  rtw_cmd_t    cmd_i           = RTW_CMD_START;
  logic [7:0]  wr_byte_i       = 8'h00;
  logic        nack_i          = 1'b0;
  logic        cmd_ready_o, done_o, ack_o, wr_stb_o, sel_o;
  logic [7:0]  rd_byte_o, wr_data_o;
  logic [5:0]  wr_addr_o, ptr_o;
  logic [13:0] stored_q [$];
  logic [7:0]  mb [4]          = '{8'h12, 8'h34, 8'h56, 8'h78};
  logic [15:0] rows [4]        = '{16'h051E, 16'h3FC4, 16'h0037, 16'h2A6B};
  int          err_total       = 0;
  int          samples_checked = 0;
  int          cyc             = 0;

  always #5 ref_clk_i = ~ref_clk_i;
  always #24 lnk_clk_i = ~lnk_clk_i;

  rtw_if bus_if ();

  rtw_master #(.QTR_CYC(QTR)) u_rtw_master (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .wr_byte_i(wr_byte_i), .nack_i(nack_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rd_byte_o(rd_byte_o), .ack_o(ack_o));

  rtw_slave u_rtw_slave (.lnk_clk_i(lnk_clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if), .wr_stb_o(wr_stb_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .ptr_o(ptr_o), .sel_o(sel_o));

  rtw_checker u_rtw_checker (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl(bus_if.scl), .sda(bus_if.sda),
    .sda_s_oe_n(bus_if.sda_s_oe_n));

  always @(posedge lnk_clk_i) begin
    if (wr_stb_o === 1'b1) stored_q.push_back({wr_addr_o, wr_data_o});
  end

  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic do_cmd(input rtw_cmd_t c, input logic [7:0] b, input logic nk);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i       <= c;
    wr_byte_i   <= b;
    nack_i      <= nk;
    do @(posedge ref_clk_i); while (cmd_ready_o !== 1'b1);
    cmd_valid_i <= 1'b0;
    while (done_o !== 1'b1 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 2000) chk("done", 16'h0001, 16'h0000);
  endtask : do_cmd

  task automatic wb(input logic [7:0] b, input logic ak);
    do_cmd(RTW_CMD_WRITE, b, 1'b0);
    chk("ack", {15'h0000, ak}, {15'h0000, ack_o});
  endtask : wb

  task automatic rb(input logic nk, input logic [7:0] e);
    do_cmd(RTW_CMD_READ, 8'h00, nk);
    chk("rd_byte", {8'h00, e}, {8'h00, rd_byte_o});
  endtask : rb

  task automatic xfer_start(input logic [7:0] a, input logic ak);
    do_cmd(RTW_CMD_START, 8'h00, 1'b0);
    wb(a, ak);
  endtask : xfer_start

  task automatic xfer_stop;
    do_cmd(RTW_CMD_STOP, 8'h00, 1'b0);
    repeat (40) @(posedge ref_clk_i);
  endtask : xfer_stop

  task automatic exp_st(input logic [5:0] a, input logic [7:0] d);
    logic [13:0] v;
    v = {14{1'bx}};
    if (stored_q.size() > 0) v = stored_q.pop_front();
    chk("stored", {2'h0, a, d}, {2'h0, v});
  endtask : exp_st

  task automatic chk_ptr(input logic [5:0] e);
    chk("ptr", {10'h000, e}, {10'h000, ptr_o});
  endtask : chk_ptr

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    repeat (40) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    chk("reset", 16'h000B, {4'h0, ptr_o, sel_o, wr_stb_o, cmd_ready_o, done_o, bus_if.scl, bus_if.sda});
    foreach (rows[i]) begin
      xfer_start(8'hD0, 1'b1);
      chk("sel", 16'h0001, {15'h0000, sel_o});
      wb(rows[i][15:8], 1'b1);
      wb(rows[i][7:0], 1'b1);
      xfer_stop();
      exp_st(rows[i][13:8], rows[i][7:0]);
      chk_ptr(rows[i][13:8] + 6'h01);
      chk("sel_idle", 16'h0000, {15'h0000, sel_o});
    end
    xfer_start(8'hD0, 1'b1);
    wb(8'h3F, 1'b1);
    foreach (mb[i]) wb(mb[i], 1'b1);
    xfer_stop();
    foreach (mb[i]) exp_st(6'(8'h3F + i), mb[i]);
    chk_ptr(6'h03);
    xfer_start(8'hD0, 1'b1);
    wb(8'h3F, 1'b1);
    xfer_start(8'hD1, 1'b1);
    rb(1'b0, 8'h12);
    rb(1'b0, 8'h34);
    rb(1'b1, 8'h56);
    xfer_stop();
    chk_ptr(6'h02);
    xfer_start(8'hD1, 1'b1);
    rb(1'b1, 8'h78);
    xfer_stop();
    xfer_start(8'hD3, 1'b0);
    rb(1'b1, 8'hFF);
    xfer_start(8'hD2, 1'b0);
    wb(8'h3C, 1'b0);
    xfer_start(8'hD0, 1'b1);
    wb(8'h05, 1'b1);
    xfer_stop();
    chk_ptr(6'h05);
    chk("stray_store", 16'h0000, 16'(stored_q.size()));
    // reset in mid-run: pointer back to 00h, then read from it
    sys_rst_i <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    chk("reset_mid", 16'h000B, {4'h0, ptr_o, sel_o, wr_stb_o, cmd_ready_o, done_o, bus_if.scl, bus_if.sda});
    xfer_start(8'hD1, 1'b1);
    rb(1'b1, 8'h34);
    xfer_stop();
    chk_ptr(6'h01);
    wrap_up();
  end
endmodule : tb_top
